// *** hw/fq_bus_cycle.sv ***
// Single asynchronous flash read or write cycle generator
`timescale 1ns/1ps
module fq_bus_cycle (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic we_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [15:0] dq_in,
  output logic done_out,
  output logic [15:0] rdata_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic [23:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe_out
);
  typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_REC} fq_cy_t;
  fq_cy_t state_r; // Cycle phase
  logic [3:0] cnt_r; // Cycles left in phase

  // Strobe sequencing: assert, hold for access or pulse time, recover
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= CY_IDLE;
      cnt_r <= 4'h0;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      addr_out <= 24'h000000;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      unique case (state_r)
        CY_IDLE:
        begin
          // Launch a cycle; address and data stay stable throughout
          if (start_in)
          begin
            addr_out <= addr_in;
            dq_out <= wdata_in;
            dq_oe_out <= we_in;
            ce_n_out <= 1'b0;
            we_n_out <= !we_in;
            oe_n_out <= we_in;
            cnt_r <= we_in ? 4'(fq_pkg::WP_CYC - 1) : 4'(fq_pkg::ACCESS_CYC - 1);
            state_r <= CY_ACT;
          end
        end
        CY_ACT:
        begin
          // Sample read data at the end of access time
          if (cnt_r == 4'h0)
          begin
            rdata_out <= dq_in;
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            cnt_r <= 4'(fq_pkg::REC_CYC - 1);
            state_r <= CY_REC;
          end
          else
          begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        CY_REC:
        begin
          // Data held one recovery period past the write strobe
          if (cnt_r == 4'h0)
          begin
            dq_oe_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= CY_IDLE;
          end
          else
          begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
      endcase
    end
  end
endmodule

// *** hw/fq_flash_host.sv ***
// Wishbone-driven host controller for flash query, extra block and buffered program
`timescale 1ns/1ps
// Functional notes
// - Host exits extended mode after programming.
// - Buffer data addresses stay in one page; checked only in non-enhanced mode, enhanced loads check consecutive order.
// - Enhanced load starts at block offset zero, consecutive.
// - Error gets reset; abort gets abort-and-reset.
// - After error flag, re-read the polling bit.
module fq_flash_host (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic [23:0] flash_addr_out,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_byte_n_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fq_state_t;

  fq_state_t state_r; // Sequencer state
  logic [23:0] addr_r; // Software target address
  logic [15:0] wdata_r; // Software write data
  logic [15:0] rdata_r; // Last read result
  logic cfg_byte_r; // Eight-bit bus mode
  logic [3:0] op_r; // Operation in progress
  logic [1:0] step_r; // Step within a script
  logic done_r, fail_r, abort_r, addr_err_r; // Sticky status
  logic repoll_r; // Second status read pending
  logic abort_seen_r; // Abort flag caused the re-read
  logic exp_poll_r; // Expected poll bit of last loaded data
  logic enh_r; // Enhanced buffered program in use
  logic [23:0] page_base_r; // Word index of buffer start
  logic [23:0] next_idx_r; // Next expected enhanced word index
  logic eng_start_r; // Launch pulse to cycle engine
  logic eng_done; // Cycle engine finished
  logic [15:0] eng_rdata; // Raw data from the flash
  fq_pkg::fq_step_t step; // Current script step
  logic [23:0] widx; // Word index of the target address
  logic load_ok; // Target address legal for buffer load
  logic cmd_wr, st_wr, wb_hit;

  // Merge byte lanes of a write into an existing value
  function automatic logic [31:0] fq_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Word offsets scale to byte offsets on an eight-bit bus
  function automatic logic [23:0] fq_scale(input logic [23:0] off, input logic byte_mode);
    return byte_mode ? {off[22:0], 1'b0} : off;
  endfunction

  // Flash bus steps of each operation
  function automatic fq_pkg::fq_step_t fq_script(input logic [3:0] op, input logic [1:0] stp,
                                                 input logic [23:0] a, input logic [15:0] d,
                                                 input logic bm);
    fq_pkg::fq_step_t s;
    s = '{last: 1'b1, we: 1'b0, addr: a, data: 16'h0000};
    unique case (op)
      fq_pkg::OP_WRITE, fq_pkg::OP_LOAD: s = '{last: 1'b1, we: 1'b1, addr: a, data: d};
      fq_pkg::OP_QUERY: s.addr = fq_scale(a, bm);
      fq_pkg::OP_RESET: s = '{last: 1'b1, we: 1'b1, addr: 24'h000000, data: fq_pkg::RESET_DATA};
      fq_pkg::OP_EXIT_EXT, fq_pkg::OP_ABORT_RESET:
      begin
        s.we = 1'b1;
        s.last = 1'b0;
        unique case (stp)
          2'h0: {s.addr, s.data} = {fq_scale(fq_pkg::UNLOCK1_ADDR, bm), fq_pkg::UNLOCK1_DATA};
          2'h1: {s.addr, s.data} = {fq_scale(fq_pkg::UNLOCK2_ADDR, bm), fq_pkg::UNLOCK2_DATA};
          2'h2:
          begin
            s.addr = fq_scale(fq_pkg::UNLOCK1_ADDR, bm);
            s.data = (op == fq_pkg::OP_EXIT_EXT) ? fq_pkg::EXIT1_DATA : fq_pkg::RESET_DATA;
            s.last = (op == fq_pkg::OP_ABORT_RESET);
          end
          2'h3: {s.last, s.addr, s.data} = {1'b1, 24'h000000, fq_pkg::EXIT2_DATA};
        endcase
      end
      default: s.we = 1'b0;
    endcase
    return s;
  endfunction

  // Current step, word index and buffer-load legality
  always_comb
  begin
    step = fq_script(op_r, step_r, addr_r, wdata_r, cfg_byte_r);
    widx = cfg_byte_r ? {1'b0, addr_r[23:1]} : addr_r;
    load_ok = enh_r ? (widx == next_idx_r)
                    : (widx[23:fq_pkg::PAGE_BITS] == page_base_r[23:fq_pkg::PAGE_BITS]);
  end

  assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign cmd_wr = wb_hit && wb_we_in && (wb_adr_in == fq_pkg::REG_CMD) && wb_sel_in[0] && (state_r == ST_IDLE);
  assign st_wr = wb_hit && wb_we_in && (wb_adr_in == fq_pkg::REG_STATUS) && wb_sel_in[0];

  // Wishbone slave: one-cycle ack, read mux, unmapped reads as zero
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end
    else
    begin
      wb_ack_out <= wb_hit;
      unique case (wb_adr_in)
        fq_pkg::REG_ADDR: wb_dat_out <= {8'h00, addr_r};
        fq_pkg::REG_WDATA: wb_dat_out <= {16'h0000, wdata_r};
        fq_pkg::REG_STATUS: wb_dat_out <= {27'h0000000, addr_err_r, abort_r, fail_r, done_r, state_r != ST_IDLE};
        fq_pkg::REG_RDATA: wb_dat_out <= {16'h0000, rdata_r};
        fq_pkg::REG_CONFIG: wb_dat_out <= {31'h00000000, cfg_byte_r};
        default: wb_dat_out <= 32'h00000000;
      endcase
    end
  end

  // Plain software registers
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      addr_r <= 24'h000000;
      wdata_r <= 16'h0000;
      cfg_byte_r <= fq_pkg::CFG_BYTE_RESET;
      flash_byte_n_out <= 1'b1;
    end
    else
    begin
      // Target registers are not changed while an operation runs
      if (wb_hit && wb_we_in && state_r == ST_IDLE)
      begin
        if (wb_adr_in == fq_pkg::REG_ADDR)
          addr_r <= 24'(fq_merge({8'h00, addr_r}, wb_dat_in, wb_sel_in));
        if (wb_adr_in == fq_pkg::REG_WDATA)
          wdata_r <= 16'(fq_merge({16'h0000, wdata_r}, wb_dat_in, wb_sel_in));
        if (wb_adr_in == fq_pkg::REG_CONFIG)
          cfg_byte_r <= wb_sel_in[0] ? wb_dat_in[fq_pkg::CFG_BYTE_BIT] : cfg_byte_r;
      end
      flash_byte_n_out <= !cfg_byte_r;
    end
  end

  // Operation sequencer with buffered-program status handling
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_IDLE;
      op_r <= 4'h0;
      step_r <= 2'h0;
      {done_r, fail_r, abort_r, addr_err_r} <= 4'h0;
      {repoll_r, abort_seen_r, exp_poll_r, enh_r, eng_start_r} <= 5'h00;
      page_base_r <= 24'h000000;
      next_idx_r <= 24'h000000;
      rdata_r <= 16'h0000;
    end
    else
    begin
      eng_start_r <= 1'b0;
      // Write-one-to-clear of sticky bits; hardware sets below win
      if (st_wr)
      begin
        done_r <= done_r & !wb_dat_in[fq_pkg::ST_DONE_BIT];
        fail_r <= fail_r & !wb_dat_in[fq_pkg::ST_FAIL_BIT];
        abort_r <= abort_r & !wb_dat_in[fq_pkg::ST_ABORT_BIT];
        addr_err_r <= addr_err_r & !wb_dat_in[fq_pkg::ST_ADDR_ERR_BIT];
      end
      unique case (state_r)
        ST_IDLE:
        begin
          // A new command clears the outcome of the previous one
          if (cmd_wr)
          begin
            op_r <= wb_dat_in[fq_pkg::CMD_OP_LSB +: 4];
            step_r <= 2'h0;
            repoll_r <= 1'b0;
            {done_r, fail_r, abort_r, addr_err_r} <= 4'h0;
            if (wb_dat_in[fq_pkg::CMD_OP_LSB +: 4] == fq_pkg::OP_BUF_BEGIN)
            begin
              // Enhanced program starts at offset zero of the block
              enh_r <= wb_dat_in[fq_pkg::CMD_ENH_BIT];
              page_base_r <= widx;
              next_idx_r <= {widx[23:fq_pkg::BLOCK_BITS], 16'h0000};
              done_r <= 1'b1;
            end
            else
            begin
              state_r <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE:
        begin
          // Illegal buffer addresses never reach the flash
          if (op_r == fq_pkg::OP_LOAD && !load_ok)
          begin
            addr_err_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          else
          begin
            if (op_r == fq_pkg::OP_LOAD)
            begin
              exp_poll_r <= wdata_r[fq_pkg::POLL_BIT];
              next_idx_r <= widx + 24'h000001;
            end
            eng_start_r <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (eng_done)
          begin
            // Query data sits on the low byte lane only
            rdata_r <= (op_r == fq_pkg::OP_QUERY) ? {8'h00, eng_rdata[7:0]} : eng_rdata;
            if (op_r == fq_pkg::OP_POLL)
            begin
              if (eng_rdata[fq_pkg::POLL_BIT] == exp_poll_r)
              begin
                done_r <= 1'b1;
                state_r <= ST_IDLE;
              end
              else if (repoll_r)
              begin
                // Confirmed failure: recover with the matching reset
                fail_r <= !abort_seen_r;
                abort_r <= abort_seen_r;
                op_r <= abort_seen_r ? fq_pkg::OP_ABORT_RESET : fq_pkg::OP_RESET;
                step_r <= 2'h0;
                state_r <= ST_ISSUE;
              end
              else
              begin
                // Flags may rise together with the poll bit: read again
                if (eng_rdata[fq_pkg::ERR_BIT] || eng_rdata[fq_pkg::ABORT_BIT])
                begin
                  repoll_r <= 1'b1;
                  abort_seen_r <= !eng_rdata[fq_pkg::ERR_BIT];
                end
                state_r <= ST_ISSUE;
              end
            end
            else if (step.last)
            begin
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end
            else
            begin
              step_r <= step_r + 2'h1;
              state_r <= ST_ISSUE;
            end
          end
        end
      endcase
    end
  end

  fq_bus_cycle u_cycle (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(eng_start_r),
    .we_in(step.we),
    .addr_in(step.addr),
    .wdata_in(step.data),
    .dq_in(flash_dq_in),
    .done_out(eng_done),
    .rdata_out(eng_rdata),
    .ce_n_out(flash_ce_n_out),
    .oe_n_out(flash_oe_n_out),
    .we_n_out(flash_we_n_out),
    .addr_out(flash_addr_out),
    .dq_out(flash_dq_out),
    .dq_oe_out(flash_dq_oe_out)
  );

  a_poll_reread: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == ST_WAIT && eng_done && op_r == fq_pkg::OP_POLL && !repoll_r
     && eng_rdata[7] != exp_poll_r && eng_rdata[5]) |=> (state_r == ST_ISSUE && repoll_r) ##1 eng_start_r)
    else $error("error flag not followed by a second status read");
  a_fail_reset: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == ST_WAIT && eng_done && op_r == fq_pkg::OP_POLL && repoll_r && !abort_seen_r
     && eng_rdata[7] != exp_poll_r) |=> (op_r == fq_pkg::OP_RESET && fail_r) ##[1:3] !flash_we_n_out)
    else $error("failed program not followed by plain reset");
  a_abort_reset: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == ST_WAIT && eng_done && op_r == fq_pkg::OP_POLL && repoll_r && abort_seen_r
     && eng_rdata[7] != exp_poll_r) |=> op_r == fq_pkg::OP_ABORT_RESET && abort_r && !fail_r)
    else $error("aborted program not followed by abort reset");
  a_page_refuse: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == ST_ISSUE && op_r == fq_pkg::OP_LOAD && !enh_r
     && widx[23:5] != page_base_r[23:5]) |=> !eng_start_r && addr_err_r && state_r == ST_IDLE)
    else $error("load outside buffer page reached the flash");
  a_enh_consec: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == ST_ISSUE && op_r == fq_pkg::OP_LOAD && enh_r && load_ok)
     |=> next_idx_r == $past(widx) + 24'h000001 && eng_start_r)
    else $error("enhanced load address not advanced by one");
  a_exit_done: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_r == ST_WAIT && eng_done && op_r == fq_pkg::OP_EXIT_EXT && step_r == 2'h3)
     |=> state_r == ST_IDLE && done_r && $past(step.data) == 16'h0000)
    else $error("exit from extended mode did not end on its last write");
  a_ack_pulse: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("bus ack held longer than one cycle");
endmodule

// *** hw/fq_pkg.sv ***
// Shared constants and types for the flash query and extra-block host controller
package fq_pkg;
  // Bus widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // Software register byte offsets
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  // Operation codes written to the command register
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_QUERY = 4'h3;
  localparam logic [3:0] OP_BUF_BEGIN = 4'h4;
  localparam logic [3:0] OP_LOAD = 4'h5;
  localparam logic [3:0] OP_POLL = 4'h6;
  localparam logic [3:0] OP_EXIT_EXT = 4'h7;
  localparam logic [3:0] OP_RESET = 4'h8;
  localparam logic [3:0] OP_ABORT_RESET = 4'h9;
  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ENH_BIT = 8;
  // Status register bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_FAIL_BIT = 2;
  localparam int ST_ABORT_BIT = 3;
  localparam int ST_ADDR_ERR_BIT = 4;
  // Config register bit and reset value
  localparam int CFG_BYTE_BIT = 0;
  localparam logic CFG_BYTE_RESET = 1'b0;
  // Status word bits read back from the flash during polling
  localparam int POLL_BIT = 7;
  localparam int ERR_BIT = 5;
  localparam int ABORT_BIT = 1;
  // Buffer page and block sizes as address bit counts (words)
  localparam int PAGE_BITS = 5;
  localparam int BLOCK_BITS = 16;
  // Command data and unlock addresses, word offsets
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 24'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 24'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] RESET_DATA = 16'h00F0;
  localparam logic [DATA_W-1:0] EXIT1_DATA = 16'h0090;
  localparam logic [DATA_W-1:0] EXIT2_DATA = 16'h0000;
  // Timing: clock period and flash strobe times
  localparam int CLK_PERIOD_PS = 25000;
  localparam int T_ACCESS_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_REC_NS = 20;
  localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WP_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_CYC = (T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // One flash bus step of a command script
  typedef struct packed {
    logic last;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fq_step_t;
endpackage

// *** tb/fq_flash_host_tb.sv ***
// Testbench for the flash host controller against the device model
`timescale 1ns/1ps
module fq_flash_host_tb;
  localparam logic [63:0] UID = 64'h1357_9BDF_2468_ACE0; // Arbitrary value
  logic clock_in;
  logic rst_n_in;
  logic wb_cyc, wb_stb, wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_out, rd, st;
  logic wb_ack_out, ce_n, oe_n, we_n, dq_oe, byte_n;
  logic [23:0] f_addr, last_addr;
  logic [15:0] dq_host, dq_dev, last_data;
  logic [1:0] mode;
  logic [7:0] qval [17] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'h0D, 8'h02, 8'h01, 8'h00, 8'h08, 8'h00,
                            8'h00, 8'h02, 8'hB5, 8'hC5, 8'h05, 8'h01};
  int errors, comparisons, i;
  fq_flash_host dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
    .flash_addr_out(f_addr), .flash_dq_in(dq_dev), .flash_dq_out(dq_host), .flash_dq_oe_out(dq_oe),
    .flash_byte_n_out(byte_n));
  fq_flash_model #(.BOOT_FLAG(8'h05), .UNIQUE_ID(UID)) model_u (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .byte_n_in(byte_n), .addr_in(f_addr), .dq_in(dq_oe ? dq_host : ~dq_host), .mode_in(mode), .dq_out(dq_dev),
    .last_addr_out(last_addr), .last_data_out(last_data));
  // Free-running clock
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // Verdict and end of run
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD time %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One Wishbone classic cycle, held until ack
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    do
    begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    // No ack within the bound ends the run as a failure
    if (wb_ack_out !== 1'b1)
    begin
      errors++;
      results();
    end
    q = wb_dat_out;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // Wait until busy drops, status left in st
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, fq_pkg::REG_STATUS, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 200);
    if (st[0] !== 1'b0)
    begin
      errors++;
      results();
    end
  endtask
  // Clear sticky bits, issue an operation, wait for it
  task automatic op(input logic [3:0] code, input logic enh);
    wr(fq_pkg::REG_STATUS, 32'h1E);
    wr(fq_pkg::REG_CMD, {23'h0, enh, 4'h0, code});
    wait_idle();
  endtask
  // Flash read through one operation and RDATA
  task automatic frd(input logic [3:0] code, input logic [23:0] a, input logic [15:0] e);
    wr(fq_pkg::REG_ADDR, {8'h0, a});
    op(code, 1'b0);
    xfer(1'b0, fq_pkg::REG_RDATA, 32'h0, rd);
    chk(rd, {16'h0, e});
  endtask
  // Flash command write through one operation
  task automatic fwr(input logic [23:0] a, input logic [15:0] d);
    wr(fq_pkg::REG_ADDR, {8'h0, a});
    wr(fq_pkg::REG_WDATA, {16'h0, d});
    op(fq_pkg::OP_WRITE, 1'b0);
  endtask
  // Buffer load at one address, expected status
  task automatic load(input logic [23:0] a, input logic [31:0] e);
    wr(fq_pkg::REG_ADDR, {8'h0, a});
    op(fq_pkg::OP_LOAD, 1'b0);
    chk(st, e);
  endtask
  // Main sequence
  initial
  begin
    rst_n_in = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    mode = 2'd0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    chk({ce_n, oe_n, we_n, dq_oe, byte_n}, 32'h1D);
    xfer(1'b0, fq_pkg::REG_CONFIG, 32'h0, rd);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0, rd);
    chk(rd, 32'h0);
    // Query table, word mode
    fwr(24'h55, 16'h0098);
    for (i = 0; i < 17; i++)
      frd(fq_pkg::OP_QUERY, 24'(i) + 24'h40, {8'h0, qval[i]});
    for (i = 0; i < 4; i++)
      frd(fq_pkg::OP_READ, 24'(i) + 24'h61, UID[16*i +: 16]);
    // Byte mode query offsets
    wr(fq_pkg::REG_CONFIG, 32'h1);
    @(posedge clock_in);
    chk(byte_n, 32'h0);
    frd(fq_pkg::OP_QUERY, 24'h40, 16'h0050);
    frd(fq_pkg::OP_QUERY, 24'h4D, 16'h00B5);
    wr(fq_pkg::REG_CONFIG, 32'h0);
    // Address write while busy is ignored
    wr(fq_pkg::REG_CMD, {28'h0, fq_pkg::OP_READ});
    wr(fq_pkg::REG_ADDR, 32'h777);
    wait_idle();
    xfer(1'b0, fq_pkg::REG_ADDR, 32'h0, rd);
    chk(rd, 32'h4D);
    // Extra block mode and exit
    fwr(24'h0, 16'h00F0);
    fwr(24'h0, 16'h0088);
    frd(fq_pkg::OP_READ, 24'h10, 16'hE010);
    frd(fq_pkg::OP_READ, 24'h7F, 16'hE07F);
    // Lock indicator and one-time protect bit of a customer-lockable part
    frd(fq_pkg::OP_READ, 24'h80, 16'h0001);
    fwr(24'h80, 16'h0000);
    fwr(24'h80, 16'h0001);
    frd(fq_pkg::OP_READ, 24'h80, 16'h0000);
    op(fq_pkg::OP_EXIT_EXT, 1'b0);
    chk({last_addr, last_data[7:0]}, 32'h0);
    frd(fq_pkg::OP_READ, 24'h10, 16'h0000);
    // Buffer page limits
    wr(fq_pkg::REG_ADDR, 32'h100);
    op(fq_pkg::OP_BUF_BEGIN, 1'b0);
    wr(fq_pkg::REG_WDATA, 32'h80);
    load(24'h105, 32'h2);
    chk(last_data, 32'h80);
    load(24'h120, 32'h12);
    // Polling: good, error, abort
    op(fq_pkg::OP_POLL, 1'b0);
    chk(st, 32'h2);
    mode <= 2'd1;
    op(fq_pkg::OP_POLL, 1'b0);
    chk(st, 32'h6);
    chk({last_addr, last_data[7:0]}, 32'hF0);
    mode <= 2'd2;
    op(fq_pkg::OP_POLL, 1'b0);
    chk(st, 32'hA);
    chk({last_addr, last_data[7:0]}, 32'h555F0);
    mode <= 2'd0;
    // Enhanced load order from block start
    wr(fq_pkg::REG_ADDR, 32'h10005);
    op(fq_pkg::OP_BUF_BEGIN, 1'b1);
    load(24'h10005, 32'h12);
    load(24'h10000, 32'h2);
    load(24'h10002, 32'h12);
    load(24'h10001, 32'h2);
    // Plain resets
    op(fq_pkg::OP_RESET, 1'b0);
    chk({last_addr, last_data[7:0]}, 32'hF0);
    op(fq_pkg::OP_ABORT_RESET, 1'b0);
    chk({last_addr, last_data[7:0]}, 32'h555F0);
    results();
  end
endmodule

// *** tb/fq_flash_model.sv ***
// Behavioural flash device model: query table, extra block and status polling
`timescale 1ns/1ps
module fq_flash_model #(
  parameter logic [7:0] BOOT_FLAG = 8'h05,
  parameter logic FACTORY_LOCKED = 1'b0, // Extra block locked at manufacture
  parameter logic [63:0] UNIQUE_ID = 64'h1357_9BDF_2468_ACE0 // Arbitrary value
) (
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic byte_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic [1:0] mode_in,
  output logic [15:0] dq_out,
  output logic [23:0] last_addr_out,
  output logic [15:0] last_data_out
);
  logic query_r; // Query mode active
  logic ext_r; // Extra block mode active
  logic exit_arm_r; // First exit word seen
  logic protect_bit_r; // Extra block protect bit, zero once protected
  logic [15:0] drive_r; // Last value put on the bus
  logic [15:0] val; // Value for the current read
  logic [23:0] word; // Word offset of the access
  initial
  begin
    query_r = 1'b0;
    ext_r = 1'b0;
    exit_arm_r = 1'b0;
    protect_bit_r = !FACTORY_LOCKED;
    drive_r = 16'h0000;
    last_addr_out = 24'h000000;
    last_data_out = 16'h0000;
  end
  // Byte mode offsets are halved back to words
  assign word = byte_n_in ? addr_in : {1'b0, addr_in[23:1]};
  // Extended query table contents
  function automatic logic [15:0] qtab(input logic [23:0] o);
    case (o)
      24'h40: qtab = 16'h0050;
      24'h41: qtab = 16'h0052;
      24'h42: qtab = 16'h0049;
      24'h43: qtab = 16'h0031;
      24'h44: qtab = 16'h0033;
      24'h45: qtab = 16'h000D;
      24'h46: qtab = 16'h0002;
      24'h47: qtab = 16'h0001;
      24'h49: qtab = 16'h0008;
      24'h4C: qtab = 16'h0002;
      24'h4D: qtab = 16'h00B5;
      24'h4E: qtab = 16'h00C5;
      24'h4F: qtab = {8'h00, BOOT_FLAG};
      24'h50: qtab = 16'h0001;
      24'h61: qtab = UNIQUE_ID[15:0];
      24'h62: qtab = UNIQUE_ID[31:16];
      24'h63: qtab = UNIQUE_ID[47:32];
      24'h64: qtab = UNIQUE_ID[63:48];
      default: qtab = 16'h0000;
    endcase
  endfunction
  // Read value: query word, extra block word or status word
  always_comb
  begin
    if (query_r)
      val = qtab(word);
    else if (ext_r && word < 24'h80)
      val = 16'hE000 | word[15:0];
    else if (ext_r && word == 24'h80)
      val = {8'h00, FACTORY_LOCKED, 6'h00, protect_bit_r};
    else if (mode_in == 2'd1)
      val = {8'h00, ~last_data_out[7], 1'b0, 1'b1, 5'h00};
    else if (mode_in == 2'd2)
      val = {8'h00, ~last_data_out[7], 5'h00, 1'b1, 1'b0};
    else
      val = last_data_out;
    if (!byte_n_in)
      val[15:8] = 8'h00;
  end
  // Remember what was driven so a released bus shows its inverse
  always @(val or ce_n_in or oe_n_in)
    if (!ce_n_in && !oe_n_in)
      drive_r = val;
  assign dq_out = (!ce_n_in && !oe_n_in) ? val : ~drive_r;
  // Command decode at the end of each write strobe
  always @(posedge we_n_in)
  begin
    last_addr_out <= addr_in;
    last_data_out <= dq_in;
    exit_arm_r <= (dq_in[7:0] == 8'h90);
    if (dq_in[7:0] == 8'h98)
      query_r <= 1'b1;
    else if (dq_in[7:0] == 8'hF0)
    begin
      query_r <= 1'b0;
      ext_r <= 1'b0;
    end
    else if (dq_in[7:0] == 8'h88)
      ext_r <= 1'b1;
    else if (dq_in[7:0] == 8'h00 && exit_arm_r)
      ext_r <= 1'b0;
    // One-time protection: a zero can be written, never a one
    if (ext_r && word == 24'h80 && !dq_in[0])
      protect_bit_r <= 1'b0;
  end
endmodule
